// ===== core/pfc_host.sv
// Host controller driving a parallel NOR flash word interface through its pins
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ns
module pfc_host #(
    parameter int PROT_PULSE_CYC   = pfc_pkg::PROT_CYC,
    parameter int UNPROT_PULSE_CYC = pfc_pkg::UNPROT_CYC,
    parameter int MAX_TRIES        = pfc_pkg::MAX_TRIES,
    parameter int POLL_LIMIT       = pfc_pkg::POLL_LIMIT
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // Software register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Flash control pins
    output logic             flash_ce_n,
    output logic             flash_oe_n,
    output logic             flash_we_n,
    output logic [18:0]      flash_addr,
    // Flash data pins, two-way
    input  wire logic [15:0] flash_dq_i,
    output logic      [15:0] flash_dq_o,
    output logic             flash_dq_oe,
    // Elevated identification voltage switches for A9 and output enable
    output logic             flash_a9_hv_en,
    output logic             flash_oe_hv_en
);
    localparam int CW = pfc_pkg::CNT_W;

    if (PROT_PULSE_CYC < 1 || PROT_PULSE_CYC >= (1 << CW) ||
        UNPROT_PULSE_CYC < 1 || UNPROT_PULSE_CYC >= (1 << CW) ||
        MAX_TRIES < 1 || MAX_TRIES > 65535 || POLL_LIMIT < 2 || POLL_LIMIT > 65535) begin : g_chk
        $error("pfc_host parameter out of range");
    end

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_RD   = 6'h02,
        ST_WSET = 6'h04,
        ST_WLO  = 6'h08,
        ST_WHI  = 6'h10,
        ST_REC  = 6'h20
    } pfc_fsm_t;

    typedef struct packed {
        pfc_fsm_t                           fsm;
        logic [CW-1:0]                      cnt;
        logic [CW-1:0]                      plen;
        pfc_pkg::pfc_op_t                   op;
        pfc_pkg::pfc_after_t                after;
        logic [pfc_pkg::ADDR_W-1:0]         addr;
        logic [pfc_pkg::DATA_W-1:0]         wdata;
        logic [pfc_pkg::DATA_W-1:0]         rdata;
        logic [pfc_pkg::ADDR_W-1:0]         pa;
        logic [pfc_pkg::DATA_W-1:0]         dq;
        logic                               dq_oe;
        logic                               ce_n;
        logic                               oe_n;
        logic                               we_n;
        logic                               a9_hv;
        logic                               oe_hv;
        logic                               busy;
        logic                               done;
        logic                               err;
        logic                               first;
        logic                               last6;
        logic [pfc_pkg::BLK_W-1:0]          blk;
        logic [15:0]                        tries;
        logic [pfc_pkg::NBLK-1:0]           pmask;
        logic [31:0]                        reg_rdata;
    } pfc_host_st_t;

    pfc_host_st_t              r;
    pfc_host_st_t              n;
    logic [pfc_pkg::DATA_W-1:0] dq_s;

    pfc_sync #(
        .W (pfc_pkg::DATA_W)
    ) u_dq_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .d       (flash_dq_i),
        .q       (dq_s)
    );

    // Read cycle: select and output enable low, write strobe high
    function automatic pfc_host_st_t launch_rd(input pfc_host_st_t s);
        pfc_host_st_t t;
        t       = s;
        t.fsm   = ST_RD;
        t.ce_n  = 1'b0;
        t.oe_n  = 1'b0;
        t.we_n  = 1'b1;
        t.dq_oe = 1'b0;
        t.oe_hv = 1'b0;
        t.cnt   = CW'(pfc_pkg::RD_WAIT - 1);
        return t;
    endfunction

    // Write cycle: output enable stays high so the cycle is never taken as a read
    function automatic pfc_host_st_t launch_wr(input pfc_host_st_t s, input int len);
        pfc_host_st_t t;
        t       = s;
        t.fsm   = ST_WSET;
        t.ce_n  = 1'b0;
        t.oe_n  = 1'b1;
        t.we_n  = 1'b1;
        t.dq_oe = 1'b1;
        t.plen  = CW'(len - 1);
        t.cnt   = CW'(pfc_pkg::SETUP_CYC - 1);
        return t;
    endfunction

    // Elevated-voltage strobe for protect or unprotect, data held at a defined level
    function automatic pfc_host_st_t launch_pulse(input pfc_host_st_t s, input int len);
        pfc_host_st_t t;
        t       = launch_wr(s, len);
        t.dq    = '0;
        t.a9_hv = 1'b1;
        t.oe_hv = 1'b1;
        return t;
    endfunction

    function automatic pfc_host_st_t finish(input pfc_host_st_t s);
        pfc_host_st_t t;
        t       = s;
        t.fsm   = ST_IDLE;
        t.busy  = 1'b0;
        t.done  = 1'b1;
        t.a9_hv = 1'b0;
        t.oe_hv = 1'b0;
        return t;
    endfunction

    always_comb begin
        n           = r;
        n.reg_rdata = '0;
        if (r.cnt != '0) begin
            n.cnt = r.cnt - 1'b1;
        end

        // Register reads; data stand in the next cycle only
        if (reg_rd) begin
            case (reg_addr)
                pfc_pkg::REG_CTRL:   n.reg_rdata = {29'h0, r.op};
                pfc_pkg::REG_ADDR:   n.reg_rdata = {13'h0, r.addr};
                pfc_pkg::REG_WDATA:  n.reg_rdata = {16'h0, r.wdata};
                pfc_pkg::REG_RDATA:  n.reg_rdata = {16'h0, r.rdata};
                pfc_pkg::REG_STATUS: n.reg_rdata = {29'h0, r.err, r.done, r.busy};
                pfc_pkg::REG_PMASK:  n.reg_rdata = {16'h0, r.pmask};
                pfc_pkg::REG_TRIES:  n.reg_rdata = {16'h0, r.tries};
                default:             n.reg_rdata = '0;
            endcase
        end

        // Writes while busy are ignored so an operation never sees its inputs move
        if (reg_wr && !r.busy) begin
            case (reg_addr)
                pfc_pkg::REG_ADDR:  n.addr  = reg_wdata[pfc_pkg::ADDR_W-1:0];
                pfc_pkg::REG_WDATA: n.wdata = reg_wdata[pfc_pkg::DATA_W-1:0];
                pfc_pkg::REG_PMASK: n.pmask = reg_wdata[pfc_pkg::NBLK-1:0];
                default: ;
            endcase
        end

        unique case (r.fsm)
            ST_IDLE: begin
                if (reg_wr && reg_addr == pfc_pkg::REG_CTRL) begin
                    n.op    = pfc_pkg::pfc_op_t'(reg_wdata[2:0]);
                    n.busy  = 1'b1;
                    n.done  = 1'b0;
                    n.err   = 1'b0;
                    n.first = 1'b1;
                    n.tries = '0;
                    n.blk   = '0;
                    n.pa    = r.addr;
                    n.dq    = r.wdata;
                    n.after = pfc_pkg::AF_DONE;
                    // Array reads need no command, even straight after power-up
                    case (pfc_pkg::pfc_op_t'(reg_wdata[2:0]))
                        pfc_pkg::OP_READ: n = launch_rd(n);
                        pfc_pkg::OP_POLL: n = launch_rd(n);
                        pfc_pkg::OP_WRITE: n = launch_wr(n, pfc_pkg::WE_CYC);
                        pfc_pkg::OP_RESET: begin
                            n.dq = pfc_pkg::RESET_CMD_DATA;
                            n    = launch_wr(n, pfc_pkg::WE_CYC);
                        end
                        pfc_pkg::OP_HVID: begin
                            n.a9_hv = 1'b1;
                            if (!r.addr[pfc_pkg::A_BIT6] && !r.addr[pfc_pkg::A_BIT1] &&
                                !r.addr[pfc_pkg::A_BIT0]) begin
                                n.pa[pfc_pkg::A_BIT8] = 1'b1;
                            end
                            n = launch_rd(n);
                        end
                        pfc_pkg::OP_PROTECT: begin
                            n.pa = '0;
                            n.pa[pfc_pkg::BLK_LSB +: pfc_pkg::BLK_W] =
                                r.addr[pfc_pkg::BLK_LSB +: pfc_pkg::BLK_W];
                            n.pa[pfc_pkg::A_BIT1] = 1'b1;
                            n.after = pfc_pkg::AF_READ;
                            n = launch_pulse(n, PROT_PULSE_CYC);
                        end
                        pfc_pkg::OP_UNPROT: begin
                            if (r.pmask != {pfc_pkg::NBLK{1'b1}}) begin
                                n = finish(n);
                                n.err = 1'b1;
                            end else begin
                                n.pa = '0;
                                n.pa[pfc_pkg::A_BIT6] = 1'b1;
                                n.pa[pfc_pkg::A_BIT1] = 1'b1;
                                n.after = pfc_pkg::AF_READ;
                                n = launch_pulse(n, UNPROT_PULSE_CYC);
                            end
                        end
                        default: begin
                            n = finish(n);
                            n.err = 1'b1;
                        end
                    endcase
                end
            end
            ST_WSET: begin
                // Address settles before the strobe's falling edge; select falls together with the address
                if (r.cnt == '0) begin
                    n.we_n = 1'b0;
                    n.cnt  = r.plen;
                    n.fsm  = ST_WLO;
                end
            end
            ST_WLO: begin
                if (r.cnt == '0) begin
                    n.we_n = 1'b1;
                    n.cnt  = CW'(pfc_pkg::HOLD_CYC - 1);
                    n.fsm  = ST_WHI;
                end
            end
            ST_WHI: begin
                // Data and select held past the strobe's rising edge
                if (r.cnt == '0) begin
                    n.ce_n  = 1'b1;
                    n.dq_oe = 1'b0;
                    n.oe_hv = 1'b0;
                    n.cnt   = CW'(pfc_pkg::REC_CYC - 1);
                    n.fsm   = ST_REC;
                end
            end
            ST_RD: begin
                if (r.cnt == '0) begin
                    // Sampled only while selected and enabled; a floating bus is never read
                    n.rdata = dq_s;
                    n.ce_n  = 1'b1;
                    n.oe_n  = 1'b1;
                    n.cnt   = CW'(pfc_pkg::REC_CYC - 1);
                    n.fsm   = ST_REC;
                    n.after = pfc_pkg::AF_DONE;
                    case (r.op)
                        pfc_pkg::OP_POLL: begin
                            n.first = 1'b0;
                            n.last6 = dq_s[pfc_pkg::DQ_TOGGLE];
                            n.tries = r.tries + 16'h0001;
                            if (!r.first && dq_s[pfc_pkg::DQ_TOGGLE] == r.last6 &&
                                dq_s[pfc_pkg::DQ_POLL] == r.wdata[pfc_pkg::DQ_POLL]) begin
                                n.after = pfc_pkg::AF_DONE;
                            end else if (!r.first && dq_s[pfc_pkg::DQ_TIMEOUT]) begin
                                n.err   = 1'b1;
                                n.dq    = pfc_pkg::RESET_CMD_DATA;
                                n.after = pfc_pkg::AF_WRITE;
                            end else if (r.tries == 16'(POLL_LIMIT - 1)) begin
                                n.err   = 1'b1;
                                n.dq    = pfc_pkg::RESET_CMD_DATA;
                                n.after = pfc_pkg::AF_WRITE;
                            end else begin
                                n.after = pfc_pkg::AF_READ;
                            end
                        end
                        pfc_pkg::OP_PROTECT: begin
                            if (dq_s[7:0] == pfc_pkg::PROT_OK) begin
                                n.pmask[r.pa[pfc_pkg::BLK_LSB +: pfc_pkg::BLK_W]] = 1'b1;
                            end else begin
                                n.err = 1'b1;
                            end
                        end
                        pfc_pkg::OP_UNPROT: begin
                            if (dq_s[7:0] == pfc_pkg::UNPROT_OK) begin
                                if (r.blk == pfc_pkg::BLK_W'(pfc_pkg::NBLK - 1)) begin
                                    n.pmask = '0;
                                end else begin
                                    n.blk = r.blk + 1'b1;
                                    n.pa[pfc_pkg::BLK_LSB +: pfc_pkg::BLK_W] = r.blk + 1'b1;
                                    n.after = pfc_pkg::AF_READ;
                                end
                            end else if (r.tries == 16'(MAX_TRIES - 1)) begin
                                n.tries = r.tries + 16'h0001;
                                n.err   = 1'b1;
                            end else begin
                                // Any block still set restarts the whole pulse and scan
                                n.tries = r.tries + 16'h0001;
                                n.blk   = '0;
                                n.pa[pfc_pkg::BLK_LSB +: pfc_pkg::BLK_W] = '0;
                                n.after = pfc_pkg::AF_PULSE;
                            end
                        end
                        default: ;
                    endcase
                end
            end
            ST_REC: begin
                if (r.cnt == '0) begin
                    // Helpers start from n so a register answer due this cycle survives
                    unique case (r.after)
                        pfc_pkg::AF_DONE:  n = finish(n);
                        pfc_pkg::AF_READ:  n = launch_rd(n);
                        pfc_pkg::AF_PULSE: n = launch_pulse(n, UNPROT_PULSE_CYC);
                        pfc_pkg::AF_WRITE: begin
                            n = launch_wr(n, pfc_pkg::WE_CYC);
                            n.after = pfc_pkg::AF_DONE;
                        end
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            r       <= '0;
            r.fsm   <= ST_IDLE;
            r.ce_n  <= 1'b1;
            r.oe_n  <= 1'b1;
            r.we_n  <= 1'b1;
            r.op    <= pfc_pkg::OP_READ;
            r.after <= pfc_pkg::AF_DONE;
        end else begin
            r <= n;
        end
    end

    assign reg_rdata      = r.reg_rdata;
    assign flash_ce_n     = r.ce_n;
    assign flash_oe_n     = r.oe_n;
    assign flash_we_n     = r.we_n;
    assign flash_addr     = r.pa;
    assign flash_dq_o     = r.dq;
    assign flash_dq_oe    = r.dq_oe;
    assign flash_a9_hv_en = r.a9_hv;
    assign flash_oe_hv_en = r.oe_hv;
endmodule

// ===== core/pfc_pkg.sv
// Package: constants, register map and operation codes for the parallel flash host controller
package pfc_pkg;

    // Flash word interface geometry
    localparam int ADDR_W  = 19;
    localparam int DATA_W  = 16;
    localparam int BLK_W   = 4;
    localparam int BLK_LSB = 15;
    localparam int NBLK    = 16;
    localparam int CNT_W   = 21;

    // Address bit positions used by identification and protection cycles
    localparam int A_BIT0  = 0;
    localparam int A_BIT1  = 1;
    localparam int A_BIT6  = 6;
    localparam int A_BIT8  = 8;

    // Status bits on the flash data lines
    localparam int DQ_POLL    = 7;
    localparam int DQ_TOGGLE  = 6;
    localparam int DQ_TIMEOUT = 5;

    // Command data and expected verify bytes
    localparam logic [15:0] RESET_CMD_DATA = 16'h00F0;
    localparam logic [7:0]  PROT_OK        = 8'h01;
    localparam logic [7:0]  UNPROT_OK      = 8'h00;

    // Timing, figures in their own unit, counts derived from the clock
    localparam int CLK_NS          = 8;
    localparam int ACCESS_TIME_NS  = 70;
    localparam int SYNC_STAGES     = 2;
    localparam int SETUP_NS        = 10;
    localparam int WE_LOW_NS       = 40;
    localparam int HOLD_NS         = 10;
    localparam int RECOVER_NS      = 20;
    localparam int PROT_PULSE_US   = 100;
    localparam int UNPROTECT_PULSE_TIME_US = 10000;
    localparam int ACC_CYC   = (ACCESS_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_WAIT   = ACC_CYC + SYNC_STAGES;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WE_CYC    = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC  = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int REC_CYC   = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
    localparam int PROT_CYC  = (PROT_PULSE_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int UNPROT_CYC = (UNPROTECT_PULSE_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int MAX_TRIES  = 25;
    localparam int POLL_LIMIT = 60000;

    // Register indices on the software port
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_ADDR   = 4'h1;
    localparam logic [3:0] REG_WDATA  = 4'h2;
    localparam logic [3:0] REG_RDATA  = 4'h3;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_PMASK  = 4'h5;
    localparam logic [3:0] REG_TRIES  = 4'h6;

    // Status register bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_ERR  = 2;

    typedef enum logic [2:0] {
        OP_READ    = 3'h0,
        OP_WRITE   = 3'h1,
        OP_HVID    = 3'h2,
        OP_POLL    = 3'h3,
        OP_RESET   = 3'h4,
        OP_PROTECT = 3'h5,
        OP_UNPROT  = 3'h6,
        OP_BAD     = 3'h7
    } pfc_op_t;

    typedef enum logic [1:0] {
        AF_DONE  = 2'h0,
        AF_READ  = 2'h1,
        AF_PULSE = 2'h2,
        AF_WRITE = 2'h3
    } pfc_after_t;

endpackage

// ===== core/pfc_sync.sv
// Two-stage synchroniser for the flash data inputs
`timescale 1ns/1ns
module pfc_sync #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    // Asynchronous input and synchronised output
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    if (W < 1) begin : g_chk
        $error("pfc_sync width must be at least one");
    end

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } pfc_sync_st_t;

    pfc_sync_st_t r;
    pfc_sync_st_t n;

    // First stage feeds only the second stage
    always_comb begin
        n    = r;
        n.s1 = d;
        n.s2 = r.s1;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign q = r.s2;
endmodule

// ===== tb/pfc_host_properties.sv
// Checker of the flash pin protocol kept by the host controller
`timescale 1ns/1ns
module pfc_host_properties (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // Flash pins
    input wire logic        flash_ce_n,
    input wire logic        flash_oe_n,
    input wire logic        flash_we_n,
    input wire logic [18:0] flash_addr,
    input wire logic [15:0] flash_dq_o,
    input wire logic        flash_dq_oe,
    input wire logic        flash_a9_hv_en,
    input wire logic        flash_oe_hv_en
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_rd;
        (!flash_ce_n && !flash_oe_n) [*8] ##1 (!flash_ce_n && !flash_oe_n) [*3] ##1 flash_oe_n;
    endsequence
    sequence s_we;
        (!flash_we_n) [*5] ##1 flash_we_n;
    endsequence
    a_wr_levels: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
        else $error("strobe low without select or data");
    a_we_len: assert property ($fell(flash_we_n) && !flash_a9_hv_en |-> s_we)
        else $error("write pulse length");
    a_addr_held: assert property (!flash_we_n && !$past(flash_we_n) |->
        $stable(flash_addr) && $stable(flash_dq_o))
        else $error("address moved in pulse");
    a_data_edge: assert property ($rose(flash_we_n) |-> !flash_ce_n && flash_dq_oe)
        else $error("select rose before strobe");
    a_addr_edge: assert property ($fell(flash_we_n) && !flash_a9_hv_en |-> !$past(flash_ce_n))
        else $error("strobe fell before select");
    a_no_clash: assert property (!flash_oe_n |-> !flash_dq_oe && flash_we_n)
        else $error("host drives during read");
    a_idle_float: assert property (flash_ce_n |-> !flash_dq_oe && flash_oe_n)
        else $error("activity while deselected");
    a_hv_pair: assert property (flash_oe_hv_en |-> flash_a9_hv_en && flash_oe_n)
        else $error("high voltage pairing");
    a_hv_addr: assert property (flash_oe_hv_en && !flash_we_n |->
        flash_addr[1] && !flash_addr[0])
        else $error("protect address bits");
    a_rd_len: assert property ($fell(flash_oe_n) |-> s_rd)
        else $error("read window length");
endmodule

// ===== tb/pfc_flash_model.sv
// Behavioural flash device on the far side of the host controller
`timescale 1ns/1ns
module pfc_flash_model #(
    parameter int          ACC_NS = 70,
    parameter logic [15:0] MAKER  = 16'h00A1, // Arbitrary value
    parameter logic [15:0] CFG    = 16'h00C2  // Arbitrary value
) (
    // Controls and address
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [18:0] addr,
    input  wire logic        a9_hv,
    input  wire logic        oe_hv,
    // Data bus
    input  wire logic [15:0] dq_in,
    output wire logic [15:0] dq_out
);
    logic [15:0] mem [256];
    logic [255:0] wrt = '0;
    logic [15:0] prot = 16'h0000;
    logic [18:0] la;
    logic [15:0] rv;
    logic [15:0] hold = 16'h0000;
    int          nwr = 0;
    wire         drv = !ce_n && !oe_n && !oe_hv;
    always @(negedge we_n or negedge ce_n)
        if (!we_n && !ce_n) la = addr;
    always @(posedge we_n or posedge ce_n)
        if (!(we_n && ce_n) && oe_n) begin
            if (a9_hv && la[6]) prot = 16'h0000;
            else if (a9_hv) prot[la[18:15]] = 1'b1;
            else if (!prot[la[18:15]] && la[14:8] == 7'h0) begin
                mem[la[7:0]] = dq_in;
                wrt[la[7:0]] = 1'b1;
            end
            nwr++;
        end
    // Program completes at once, so polling bits settle on the first read
    always @(addr or a9_hv or drv or prot or nwr) begin
        if (a9_hv && !addr[6] && !addr[1] && !addr[0]) rv = addr[8] ? MAKER : CFG;
        else if (a9_hv) rv = {15'h0000, prot[addr[18:15]]};
        else if (addr[14:8] == 7'h0 && wrt[addr[7:0]]) rv = mem[addr[7:0]];
        else rv = addr[15:0] ^ 16'h5A3C;
        if (drv) hold = rv;
    end
    assign #(ACC_NS) dq_out = drv ? rv : ~hold;
endmodule

// ===== tb/tb_top.sv
// Testbench of the parallel flash host controller
`timescale 1ns/1ns
module tb_top;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        ce_n, oe_n, we_n, dq_oe, a9_hv, oe_hv;
    logic [18:0] fa;
    logic [15:0] dq_o, m_dq;
    wire  [15:0] dq = dq_oe ? dq_o : m_dq;
    int          err_total = 0;
    int          check_count = 0;
    int          cyc = 0;
    logic [31:0] rd;
    always #4 sys_clk = ~sys_clk;
    pfc_host #(.PROT_PULSE_CYC(20), .UNPROT_PULSE_CYC(40), .MAX_TRIES(3), .POLL_LIMIT(8)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_ce_n(ce_n),
        .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(fa), .flash_dq_i(dq),
        .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_a9_hv_en(a9_hv), .flash_oe_hv_en(oe_hv));
    pfc_flash_model #(.MAKER(16'h00A1)) fm (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(fa),
        .a9_hv(a9_hv), .oe_hv(oe_hv), .dq_in(dq), .dq_out(m_dq));
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdr(input logic [3:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Done is sticky, so a dropped status answer only costs one more poll
    task automatic op(input logic [2:0] o);
        int n = 0;
        wr(pfc_pkg::REG_CTRL, {29'h0, o});
        rd = 32'h0;
        while (rd[pfc_pkg::ST_DONE] !== 1'b1 && n < 2000) begin
            rdr(pfc_pkg::REG_STATUS);
            n++;
        end
        if (n >= 2000) begin
            err_total++;
            $display("wrong value at %0t: operation never finished", $time);
        end
    endtask
    task automatic rdw(input logic [2:0] o, input logic [31:0] exp);
        op(o);
        rdr(pfc_pkg::REG_RDATA);
        chk(rd, exp);
    endtask
    task automatic t_rw;
        wr(pfc_pkg::REG_ADDR, 32'h1234);
        rdw(pfc_pkg::OP_READ, 32'h1234 ^ 32'h5A3C);
        wr(pfc_pkg::REG_ADDR, 32'h42);
        wr(pfc_pkg::REG_WDATA, 32'hBEEF);
        op(pfc_pkg::OP_WRITE);
        op(pfc_pkg::OP_POLL);
        chk(rd, 32'h2);
        rdw(pfc_pkg::OP_READ, 32'hBEEF);
        wr(pfc_pkg::REG_ADDR, 32'h0);
        rdw(pfc_pkg::OP_HVID, 32'h00A1);
        op(pfc_pkg::OP_RESET);
        chk(rd, 32'h2);
        rdw(pfc_pkg::OP_READ, 32'h00F0);
        $display("test read write id end");
    endtask
    task automatic t_prot;
        wr(pfc_pkg::REG_ADDR, 32'h18000);
        op(pfc_pkg::OP_PROTECT);
        chk(rd, 32'h2);
        rdr(pfc_pkg::REG_PMASK);
        chk(rd, 32'h8);
        wr(pfc_pkg::REG_ADDR, 32'h18005);
        wr(pfc_pkg::REG_WDATA, 32'h1111);
        op(pfc_pkg::OP_WRITE);
        rdw(pfc_pkg::OP_READ, 32'h8005 ^ 32'h5A3C);
        op(pfc_pkg::OP_UNPROT);
        chk(rd, 32'h6);
        wr(pfc_pkg::REG_PMASK, 32'hFFFF);
        op(pfc_pkg::OP_UNPROT);
        chk(rd, 32'h2);
        rdr(pfc_pkg::REG_PMASK);
        chk(rd, 32'h0);
        op(pfc_pkg::OP_BAD);
        chk(rd, 32'h6);
        rdr(4'hF);
        chk(rd, 32'h0);
        $display("test protect end");
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            finish_test();
        end
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_rw();
        t_prot();
        finish_test();
    end
endmodule
bind pfc_host pfc_host_properties u_props (.sys_clk(sys_clk), .rst_n(rst_n),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .flash_addr(flash_addr), .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe),
    .flash_a9_hv_en(flash_a9_hv_en), .flash_oe_hv_en(flash_oe_hv_en));
